/* src/iqcp_consts.vh */
// constants for the ingress classifier and queue policer
`ifndef IQCP_CONSTS_VH
`define IQCP_CONSTS_VH

// register byte offsets
`define IQCP_OFS_CTRL      8'h00
`define IQCP_OFS_DEFAULTS  8'h04
`define IQCP_OFS_MAPS      8'h08
`define IQCP_OFS_RATE      8'h0c
`define IQCP_OFS_EFF_RATE  8'h10
`define IQCP_OFS_DROPS     8'h14
`define IQCP_OFS_TAGMAP    8'h40
`define IQCP_TAGMAP_ENTRIES 16

// control register fields
`define IQCP_CTRL_VLAN_AWARE  0
`define IQCP_CTRL_TAG_CLASS   1
`define IQCP_CTRL_CODE_POINT  2
`define IQCP_CTRL_POL_EN      3
`define IQCP_CTRL_UNIT_MBPS   4
`define IQCP_CTRL_RST         5'h00

// defaults register fields
`define IQCP_DEF_COS_LSB      0
`define IQCP_DEF_DPL_LSB      4
`define IQCP_DEF_PCP_LSB      8
`define IQCP_DEF_DEI          12
`define IQCP_DEF_CID_LSB      16
`define IQCP_DEF_GRP_LSB      20
`define IQCP_DEFAULTS_RST     32'h0000_0000

// map selection register fields
`define IQCP_MAP_ING_LSB      0
`define IQCP_MAP_ING_EN       15
`define IQCP_MAP_EGR_LSB      16
`define IQCP_MAP_EGR_EN       31
`define IQCP_MAPS_RST         32'h0000_0000

// policer rate limits and granularity
`define IQCP_RATE_RST         24'h0001f4
`define IQCP_KBPS_MIN         24'd25
`define IQCP_KBPS_MAX         24'd13128147
`define IQCP_MBPS_MIN         24'd1
`define IQCP_MBPS_MAX         24'd13128
`define IQCP_KBPS_PER_MBPS    24'd1000
`define IQCP_RATE_STEP        24'd25
`define IQCP_COST_PER_BYTE    10'd320
`define IQCP_BUCKET_MAX       25'd4915200

// refill tick timing
`define IQCP_CLK_NS           25
`define IQCP_TICK_NS          1000
`define IQCP_TICK_CYCLES      ((`IQCP_TICK_NS + `IQCP_CLK_NS - 1) / `IQCP_CLK_NS)

`endif

/* src/iqcp_top.v */
// single-port ingress classifier, queue policer and register slave
//
// Our own choices: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "iqcp_consts.vh"

module iqcp_top (
   input  wire        clk_i,                    // 40 MHz system clock
   input  wire        rst_i,                    // synchronous, active high
   input  wire        wb_cyc_i,                 // wishbone cycle
   input  wire        wb_stb_i,                 // wishbone strobe
   input  wire        wb_we_i,                  // wishbone write
   input  wire [7:0]  wb_adr_i,                 // byte address
   input  wire [31:0] wb_dat_i,                 // write data
   input  wire [3:0]  wb_sel_i,                 // byte enables
   output wire [31:0] wb_dat_o,                 // read data
   output wire        wb_ack_o,                 // acknowledge
   input  wire        frm_valid_i,              // frame descriptor pulse
   input  wire        frm_tagged_i,             // frame carries a vlan tag
   input  wire [2:0]  frm_pcp_i,                // tag priority code point
   input  wire        frm_dei_i,                // tag drop eligible bit
   input  wire        frm_is_ip_i,              // frame is ip
   input  wire [5:0]  frm_dscp_i,               // ip code point
   input  wire [13:0] frm_len_i,                // frame length in bytes
   input  wire        qcl_hit_i,                // qos_control_list match
   input  wire [2:0]  qcl_cos_i,                // service class from list
   input  wire [1:0]  qcl_dpl_i,                // precedence from list
   output wire        res_valid_o,              // result pulse
   output wire [2:0]  service_class_o,          // queue and priority
   output wire [1:0]  drop_precedence_level_o,  // drop precedence
   output wire [2:0]  pcp_o,                    // classified priority code
   output wire        dei_o,                    // classified drop eligible
   output wire [2:0]  class_identifier_o,       // identifier for rewriting
   output wire [7:0]  ingress_map_id_o,         // ingress map id
   output wire        ingress_map_en_o,         // ingress map selected
   output wire [8:0]  egress_map_id_o,          // egress map id
   output wire        egress_map_en_o,          // egress map selected
   output wire [1:0]  early_discard_group_o,    // discard group
   output wire        drop_o                    // frame discarded by policer
);

   // tag map window base; only the top two address bits pick it out
   localparam [7:0] TAGMAP_BASE = `IQCP_OFS_TAGMAP;

   // byte-lane merge, used by every writable register except the tag map
   function [31:0] iqcp_merge;
      input [31:0] old_v;
      input [31:0] new_v;
      input [3:0]  sel;
      integer      b;
      begin
         // untouched lanes keep their old bytes
         iqcp_merge = old_v;
         for (b = 0; b < 4; b = b + 1) begin
            if (sel[b]) begin
               iqcp_merge[b*8 +: 8] = new_v[b*8 +: 8];
            end
         end
      end
   endfunction

   // tag map address decode, used by read and write
   function iqcp_is_tagmap;
      input [7:0] adr;
      begin
         iqcp_is_tagmap = (adr[7:6] == TAGMAP_BASE[7:6]);
      end
   endfunction

   // configuration state
   reg  [4:0]  ctrl_reg;              // mode bits
   reg  [31:0] defaults_reg;          // per-port defaults
   reg  [31:0] maps_reg;              // map selection
   reg  [23:0] rate_reg;              // programmed rate
   reg  [4:0]  tagmap [0:`IQCP_TAGMAP_ENTRIES-1]; // {cos,dpl} per pcp/dei
   reg  [15:0] drops_reg;             // discarded frame count
   reg         ack_reg;               // bus acknowledge
   reg  [31:0] rdat_reg;              // bus read data
   reg  [31:0] rdat_next;             // read mux
   // policer state
   reg  [24:0] bucket_reg;            // credit in 25 millibit units
   reg  [24:0] bucket_next;
   reg  [5:0]  tick_cnt_reg;          // refill divider
   reg  [23:0] eff_kbps_reg;          // enforced rate
   reg  [23:0] eff_kbps_next;
   reg  [23:0] kbps_req;              // clamped request in kbps
   // result registers
   reg         res_valid_reg;
   reg  [2:0]  cos_reg;
   reg  [1:0]  dpl_reg;
   reg  [2:0]  pcp_reg;
   reg         dei_reg;
   reg         drop_reg;
   reg  [2:0]  cos_next;
   reg  [1:0]  dpl_next;
   reg         pass_now;              // frame fits the bucket

   // bus and mode decode
   wire        bus_req   = wb_cyc_i & wb_stb_i;
   wire        bus_wr    = bus_req & wb_we_i & ack_reg;
   wire        aware     = ctrl_reg[`IQCP_CTRL_VLAN_AWARE];
   wire        pol_en    = ctrl_reg[`IQCP_CTRL_POL_EN];
   wire        use_tag   = aware & frm_tagged_i & ctrl_reg[`IQCP_CTRL_TAG_CLASS];
   wire        use_dscp  = ctrl_reg[`IQCP_CTRL_CODE_POINT] & frm_is_ip_i;
   wire [4:0]  map_entry = tagmap[{frm_pcp_i, frm_dei_i}];
   // policer arithmetic, sized to the bucket, with one extra carry bit on the refill sum
   wire        tick      = (tick_cnt_reg == (`IQCP_TICK_CYCLES - 1));
   wire [24:0] cost      = {11'h000, frm_len_i} * {15'h0000, `IQCP_COST_PER_BYTE};
   wire [24:0] step_cnt  = {1'b0, eff_kbps_reg / `IQCP_RATE_STEP};
   wire [25:0] refill_s  = {1'b0, bucket_reg} + {1'b0, step_cnt};
   wire [24:0] refilled  = (!tick) ? bucket_reg :
                           (refill_s > {1'b0, `IQCP_BUCKET_MAX}) ? `IQCP_BUCKET_MAX : refill_s[24:0];

   // merged write images, cut back to the width each register keeps
   wire [31:0] ctrl_wr   = iqcp_merge({27'h0000000, ctrl_reg}, wb_dat_i, wb_sel_i);
   wire [31:0] rate_wr   = iqcp_merge({8'h00, rate_reg}, wb_dat_i, wb_sel_i);

   // bus acknowledge: one wait cycle, dropped the cycle after it is given
   // a request held past its ack is seen as new and answered two cycles on
   always @(posedge clk_i) begin
      if (rst_i) begin
         ack_reg  <= 1'b0;
         rdat_reg <= 32'h0000_0000;
      end else begin
         ack_reg  <= bus_req & ~ack_reg;
         rdat_reg <= rdat_next;
      end
   end

   // read mux; unmapped offsets answer zero
   // registered, so the data stands in the cycle the ack stands
   always @* begin
      rdat_next = 32'h0000_0000;
      if (iqcp_is_tagmap(wb_adr_i)) begin
         // tag map words sit at four-byte steps
         rdat_next = {27'h0000000, tagmap[wb_adr_i[5:2]]};
      end else begin
         case (wb_adr_i)
            `IQCP_OFS_CTRL:     rdat_next = {27'h0000000, ctrl_reg};
            `IQCP_OFS_DEFAULTS: rdat_next = defaults_reg;
            `IQCP_OFS_MAPS:     rdat_next = maps_reg;
            `IQCP_OFS_RATE:     rdat_next = {8'h00, rate_reg};
            `IQCP_OFS_EFF_RATE: rdat_next = {8'h00, eff_kbps_reg};
            `IQCP_OFS_DROPS:    rdat_next = {16'h0000, drops_reg};
            default:            rdat_next = 32'h0000_0000;
         endcase
      end
   end

   // register writes land on the acknowledged edge only
   always @(posedge clk_i) begin : cfg_wr
      integer i;
      if (rst_i) begin
         ctrl_reg     <= `IQCP_CTRL_RST;
         defaults_reg <= `IQCP_DEFAULTS_RST;
         maps_reg     <= `IQCP_MAPS_RST;
         rate_reg     <= `IQCP_RATE_RST;
         // identity map: class follows pcp, precedence follows dei
         for (i = 0; i < `IQCP_TAGMAP_ENTRIES; i = i + 1) begin
            tagmap[i] <= {i[3:1], 1'b0, i[0]};
         end
      end else if (bus_wr) begin
         if (iqcp_is_tagmap(wb_adr_i)) begin
            // entries are five bits wide, so only the low lane counts
            if (wb_sel_i[0]) begin
               tagmap[wb_adr_i[5:2]] <= wb_dat_i[4:0];
            end
         end else begin
            case (wb_adr_i)
               `IQCP_OFS_CTRL: begin
                  ctrl_reg <= ctrl_wr[4:0];
               end
               `IQCP_OFS_DEFAULTS: begin
                  defaults_reg <= iqcp_merge(defaults_reg, wb_dat_i, wb_sel_i) & 32'h0037_1737;
               end
               `IQCP_OFS_MAPS: begin
                  maps_reg <= iqcp_merge(maps_reg, wb_dat_i, wb_sel_i) & 32'h81ff_80ff;
               end
               `IQCP_OFS_RATE: begin
                  // stored as written; clamping happens on the way to the bucket
                  rate_reg <= rate_wr[23:0];
               end
               default: begin
                  // read-only or unmapped: write ignored
               end
            endcase
         end
      end
   end

   // requested rate in kbps, clamped to the legal window of its unit
   // clamping instead of refusing keeps the request legal; rounding up can still lift a kbps rate to 13128150
   always @* begin
      kbps_req = `IQCP_KBPS_MIN;
      if (ctrl_reg[`IQCP_CTRL_UNIT_MBPS]) begin
         // Mbps window checked first, then scaled to kbps
         if (rate_reg < `IQCP_MBPS_MIN) begin
            kbps_req = `IQCP_KBPS_PER_MBPS;
         end else if (rate_reg > `IQCP_MBPS_MAX) begin
            kbps_req = `IQCP_MBPS_MAX * `IQCP_KBPS_PER_MBPS;
         end else begin
            kbps_req = rate_reg * `IQCP_KBPS_PER_MBPS;
         end
      end else begin
         // kbps unit: used as written inside its window
         if (rate_reg < `IQCP_KBPS_MIN) begin
            kbps_req = `IQCP_KBPS_MIN;
         end else if (rate_reg > `IQCP_KBPS_MAX) begin
            kbps_req = `IQCP_KBPS_MAX;
         end else begin
            kbps_req = rate_reg;
         end
      end
      // round up to a whole step; the top limit is itself below a step boundary
      eff_kbps_next = ((kbps_req + `IQCP_RATE_STEP - 24'd1) / `IQCP_RATE_STEP) * `IQCP_RATE_STEP;
   end

   // enforced rate registered to keep the divide off the bucket path
   always @(posedge clk_i) begin
      if (rst_i) begin
         eff_kbps_reg <= `IQCP_RATE_RST; // reset rate is already a whole step
      end else begin
         eff_kbps_reg <= eff_kbps_next;
      end
   end

   // one microsecond refill tick
   // forty cycles at 40 MHz; another clock needs the tick constants changed
   always @(posedge clk_i) begin
      if (rst_i) begin
         tick_cnt_reg <= 6'h00;
      end else if (tick) begin
         // wrap on the last count
         tick_cnt_reg <= 6'h00;
      end else begin
         tick_cnt_reg <= tick_cnt_reg + 6'h01;
      end
   end

   // token bucket; full while disabled so enabling starts with a burst allowance
   // a frame passes only if its whole length is covered; no partial credit
   // limitation: one bucket for the port, queues are not policed apart
   always @* begin
      pass_now    = (refilled >= cost);
      bucket_next = refilled;
      if (!pol_en) begin
         bucket_next = `IQCP_BUCKET_MAX;
      end else if (frm_valid_i && pass_now) begin
         bucket_next = refilled - cost;
      end
   end

   // bucket register; reset leaves it full
   always @(posedge clk_i) begin
      if (rst_i) begin
         bucket_reg <= `IQCP_BUCKET_MAX;
      end else begin
         bucket_reg <= bucket_next;
      end
   end

   // classification priority: list hit, then code point, then tag map, then default
   // code point path keeps the default precedence; the field carries none
   always @* begin
      cos_next = defaults_reg[`IQCP_DEF_COS_LSB +: 3];
      dpl_next = defaults_reg[`IQCP_DEF_DPL_LSB +: 2];
      if (qcl_hit_i) begin
         cos_next = qcl_cos_i;
         dpl_next = qcl_dpl_i;
      end else if (use_dscp) begin
         cos_next = frm_dscp_i[5:3];
         dpl_next = defaults_reg[`IQCP_DEF_DPL_LSB +: 2];
      end else if (use_tag) begin
         cos_next = map_entry[4:2];
         dpl_next = map_entry[1:0];
      end
   end

   // result stage, one cycle after the descriptor
   // drop and result pulses last one cycle; class outputs hold to the next frame
   always @(posedge clk_i) begin
      if (rst_i) begin
         res_valid_reg <= 1'b0;
         cos_reg       <= 3'h0;
         dpl_reg       <= 2'h0;
         pcp_reg       <= 3'h0;
         dei_reg       <= 1'b0;
         drop_reg      <= 1'b0;
         drops_reg     <= 16'h0000;
      end else begin
         res_valid_reg <= frm_valid_i;
         if (frm_valid_i) begin
            cos_reg  <= cos_next;
            dpl_reg  <= dpl_next;
            // tag values kept for tagged frames on aware ports, defaults elsewhere
            pcp_reg  <= (aware & frm_tagged_i) ? frm_pcp_i : defaults_reg[`IQCP_DEF_PCP_LSB +: 3];
            dei_reg  <= (aware & frm_tagged_i) ? frm_dei_i : defaults_reg[`IQCP_DEF_DEI];
            drop_reg <= pol_en & ~pass_now;
            // counter saturates instead of wrapping
            // only frames refused while enabled are counted
            if (pol_en && !pass_now && drops_reg != 16'hffff) begin
               drops_reg <= drops_reg + 16'h0001;
            end
         end else begin
            // no frame: drop pulse ends
            drop_reg <= 1'b0;
         end
      end
   end

   // outputs straight from flops or configuration, no logic after them
   assign wb_ack_o                = ack_reg;
   assign wb_dat_o                = rdat_reg;
   assign res_valid_o             = res_valid_reg;
   assign service_class_o         = cos_reg;
   assign drop_precedence_level_o = dpl_reg;
   assign pcp_o                   = pcp_reg;
   assign dei_o                   = dei_reg;
   assign class_identifier_o      = defaults_reg[`IQCP_DEF_CID_LSB +: 3];
   assign ingress_map_id_o        = maps_reg[`IQCP_MAP_ING_LSB +: 8];
   assign ingress_map_en_o        = maps_reg[`IQCP_MAP_ING_EN];
   assign egress_map_id_o         = maps_reg[`IQCP_MAP_EGR_LSB +: 9];
   assign egress_map_en_o         = maps_reg[`IQCP_MAP_EGR_EN];
   assign early_discard_group_o   = defaults_reg[`IQCP_DEF_GRP_LSB +: 2];
   assign drop_o                  = drop_reg;

endmodule // iqcp_top

`default_nettype wire

/* tb/iqcp_top_asserts.sv */
// concurrent checks on the classifier top ports
`timescale 1ns/1ps
`default_nettype none
module iqcp_top_chk (
   input wire logic       clk_i,
   input wire logic       rst_i,
   input wire logic       wb_cyc_i,
   input wire logic       wb_stb_i,
   input wire logic       wb_we_i,
   input wire logic       wb_ack_o,
   input wire logic       frm_valid_i,
   input wire logic       qcl_hit_i,
   input wire logic [2:0] qcl_cos_i,
   input wire logic [1:0] qcl_dpl_i,
   input wire logic       res_valid_o,
   input wire logic [2:0] service_class_o,
   input wire logic [1:0] drop_precedence_level_o,
   input wire logic [2:0] pcp_o,
   input wire logic       dei_o,
   input wire logic       drop_o,
   input wire logic [2:0] class_identifier_o,
   input wire logic [7:0] ingress_map_id_o,
   input wire logic       ingress_map_en_o,
   input wire logic [8:0] egress_map_id_o,
   input wire logic       egress_map_en_o,
   input wire logic [1:0] early_discard_group_o
);
   // one clock domain, so clock and reset are given once
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // a fresh bus request and a frame with a list match
   sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
   sequence s_hit; frm_valid_i && qcl_hit_i ##1 res_valid_o; endsequence
   property p_ack_next; s_req |=> wb_ack_o; endproperty
   property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
   property p_ack_cause; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i); endproperty
   property p_res_lat; frm_valid_i |=> res_valid_o; endproperty
   property p_res_cause; res_valid_o |-> $past(frm_valid_i); endproperty
   property p_qcl; s_hit |-> service_class_o == $past(qcl_cos_i) && drop_precedence_level_o == $past(qcl_dpl_i);
   endproperty
   // class outputs hold until the next frame, whatever software does
   property p_hold; !frm_valid_i |=> $stable({service_class_o, drop_precedence_level_o, pcp_o, dei_o});
   endproperty
   property p_drop_res; drop_o |-> res_valid_o; endproperty
   // config outputs move only after an acknowledged write
   property p_cfg_hold; !(wb_ack_o && wb_we_i) |=> $stable({class_identifier_o, early_discard_group_o,
      ingress_map_id_o, ingress_map_en_o, egress_map_id_o, egress_map_en_o}); endproperty
   a_ack_next: assert property (p_ack_next) else $error("bus request not answered next cycle");
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
   a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
   a_res_lat: assert property (p_res_lat) else $error("frame got no result");
   a_res_cause: assert property (p_res_cause) else $error("result without frame");
   a_qcl: assert property (p_qcl) else $error("list match did not override");
   a_hold: assert property (p_hold) else $error("class outputs moved between frames");
   a_drop_res: assert property (p_drop_res) else $error("drop outside result");
   a_cfg_hold: assert property (p_cfg_hold) else $error("config outputs moved");
endmodule // iqcp_top_chk
bind iqcp_top iqcp_top_chk u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_ack_o, .frm_valid_i,
   .qcl_hit_i, .qcl_cos_i, .qcl_dpl_i, .res_valid_o, .service_class_o, .drop_precedence_level_o, .pcp_o,
   .dei_o, .drop_o, .class_identifier_o, .ingress_map_id_o, .ingress_map_en_o, .egress_map_id_o,
   .egress_map_en_o, .early_discard_group_o);
`default_nettype wire

/* tb/iqcp_frame_src.sv */
// frame descriptor source standing in for the receiving port
`timescale 1ns/1ps
`default_nettype none
module iqcp_frame_src (
   input  wire logic        clk_i,     // system clock
   output logic             valid_o,   // descriptor pulse
   output logic             tagged_o,  // vlan tag present
   output logic [2:0]       pcp_o,     // tag priority code
   output logic             dei_o,     // tag drop eligible
   output logic             ip_o,      // ip frame
   output logic [5:0]       dscp_o,    // ip code point
   output logic [13:0]      len_o,     // length in bytes
   output logic             hit_o,     // control list match
   output logic [2:0]       qcos_o,    // list class
   output logic [1:0]       qdpl_o     // list precedence
);
   // quiet port at time zero
   initial begin
      {valid_o, tagged_o, pcp_o, dei_o, ip_o, dscp_o, len_o, hit_o, qcos_o, qdpl_o} = 33'h0;
   end
   // one descriptor, one cycle; fields packed in port order
   task automatic send(input logic [31:0] f);
      @(posedge clk_i);
      valid_o <= 1'b1;
      {tagged_o, pcp_o, dei_o, ip_o, dscp_o, len_o, hit_o, qcos_o, qdpl_o} <= f;
      @(posedge clk_i);
      valid_o <= 1'b0;
      // stale fields show their inverse so nothing leans on old values
      {tagged_o, pcp_o, dei_o, ip_o, dscp_o, len_o, hit_o, qcos_o, qdpl_o} <= ~f;
   endtask
endmodule // iqcp_frame_src
`default_nettype wire

/* tb/test_ingress_qos_classifier_policer.sv */
// self-checking bench for the classifier and queue policer
`timescale 1ns/1ps
`default_nettype none
module test_ingress_qos_classifier_policer;
   typedef struct packed {logic [4:0] ctrl; logic [31:0] f; logic [8:0] e;} iqcp_row_t;
   logic        clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [7:0]  wb_adr_i = 8'h00;
   logic [31:0] wb_dat_i = 32'h0, rd;
   logic [3:0]  wb_sel_i = 4'h0;
   wire  [31:0] wb_dat_o;
   wire         wb_ack_o, frm_valid_i, frm_tagged_i, frm_dei_i, frm_is_ip_i, qcl_hit_i, res_valid_o, dei_o;
   wire  [2:0]  frm_pcp_i, qcl_cos_i, service_class_o, pcp_o, class_identifier_o;
   wire  [5:0]  frm_dscp_i;
   wire  [13:0] frm_len_i;
   wire  [1:0]  qcl_dpl_i, drop_precedence_level_o, early_discard_group_o;
   wire  [7:0]  ingress_map_id_o;
   wire  [8:0]  egress_map_id_o;
   wire         ingress_map_en_o, egress_map_en_o, drop_o;
   int          err_total = 0, n_compared = 0, i;
   iqcp_row_t   rows [8];
   always #12.5 clk_i = ~clk_i;
   iqcp_top DUT (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_dat_o,
      .wb_ack_o, .frm_valid_i, .frm_tagged_i, .frm_pcp_i, .frm_dei_i, .frm_is_ip_i, .frm_dscp_i, .frm_len_i,
      .qcl_hit_i, .qcl_cos_i, .qcl_dpl_i, .res_valid_o, .service_class_o, .drop_precedence_level_o, .pcp_o,
      .dei_o, .class_identifier_o, .ingress_map_id_o, .ingress_map_en_o, .egress_map_id_o, .egress_map_en_o,
      .early_discard_group_o, .drop_o);
   iqcp_frame_src src (.clk_i, .valid_o(frm_valid_i), .tagged_o(frm_tagged_i), .pcp_o(frm_pcp_i),
      .dei_o(frm_dei_i), .ip_o(frm_is_ip_i), .dscp_o(frm_dscp_i), .len_o(frm_len_i), .hit_o(qcl_hit_i),
      .qcos_o(qcl_cos_i), .qdpl_o(qcl_dpl_i));
   // every frame is large: costs a full bucket at 320 per byte
   function automatic logic [31:0] mk(input logic t, input logic [2:0] p, input logic d, input logic ip,
      input logic [5:0] c, input logic h, input logic [2:0] qc, input logic [1:0] qd);
      return {t, p, d, ip, c, 14'h3c00, h, qc, qd};
   endfunction
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_total++;
         $display("FAIL %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // classic single wishbone cycle, no assumed latency
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      wb_sel_i <= 4'hf;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 40);
      if (wb_ack_o !== 1'b1) chk("ack", 32'h0, 32'h1);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask
   task automatic report_and_stop;
      if (err_total == 0 && n_compared > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // watchdog well past the 125 or so cycles needed
   initial begin
      #(25 * 20000);
      err_total++;
      report_and_stop;
   end
   initial begin
      // defaults: class 5, precedence 2, code 6, eligible 1, id 3, group 2
      rows = '{'{5'h03, mk(1'h1, 3'h4, 1'h0, 1'h0, 6'h00, 1'h0, 3'h0, 2'h0), {3'h4, 2'h0, 3'h4, 1'h0}},
               '{5'h03, mk(1'h1, 3'h3, 1'h1, 1'h0, 6'h00, 1'h0, 3'h0, 2'h0), {3'h1, 2'h3, 3'h3, 1'h1}},
               '{5'h01, mk(1'h1, 3'h4, 1'h1, 1'h0, 6'h00, 1'h0, 3'h0, 2'h0), {3'h5, 2'h2, 3'h4, 1'h1}},
               '{5'h02, mk(1'h1, 3'h4, 1'h1, 1'h0, 6'h00, 1'h0, 3'h0, 2'h0), {3'h5, 2'h2, 3'h6, 1'h1}},
               '{5'h03, mk(1'h0, 3'h4, 1'h0, 1'h0, 6'h00, 1'h0, 3'h0, 2'h0), {3'h5, 2'h2, 3'h6, 1'h1}},
               '{5'h03, mk(1'h1, 3'h4, 1'h0, 1'h0, 6'h00, 1'h1, 3'h7, 2'h1), {3'h7, 2'h1, 3'h4, 1'h0}},
               '{5'h07, mk(1'h1, 3'h4, 1'h0, 1'h1, 6'h18, 1'h0, 3'h0, 2'h0), {3'h3, 2'h2, 3'h4, 1'h0}},
               '{5'h07, mk(1'h1, 3'h4, 1'h0, 1'h0, 6'h18, 1'h0, 3'h0, 2'h0), {3'h4, 2'h0, 3'h4, 1'h0}}};
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      #1;
      chk("res_rst", {res_valid_o, drop_o, service_class_o}, 32'h0);
      wb(1'b0, 8'h00, 32'h0, rd); chk("ctrl_rst", rd, 32'h0);
      wb(1'b0, 8'h0c, 32'h0, rd); chk("rate_rst", rd, 32'h1f4);
      wb(1'b0, 8'h14, 32'h0, rd); chk("drops_rst", rd, 32'h0);
      wb(1'b0, 8'h20, 32'h0, rd); chk("unmapped", rd, 32'h0);
      wb(1'b1, 8'h10, 32'h1234, rd);
      wb(1'b0, 8'h10, 32'h0, rd); chk("eff_ro", rd, 32'h1f4);
      wb(1'b1, 8'h04, 32'h0023_1625, rd);
      wb(1'b1, 8'h08, 32'h81ff_80ff, rd);
      wb(1'b1, 8'h5c, 32'h0000_0007, rd);
      chk("cfg", {class_identifier_o, early_discard_group_o, ingress_map_en_o, ingress_map_id_o, egress_map_en_o,
         egress_map_id_o}, {3'h3, 2'h2, 1'h1, 8'hff, 1'h1, 9'h1ff});
      for (i = 0; i < 8; i++) begin
         wb(1'b1, 8'h00, {27'h0, rows[i].ctrl}, rd);
         src.send(rows[i].f);
         #1;
         chk("class", {res_valid_o, drop_o, service_class_o, drop_precedence_level_o, pcp_o, dei_o},
            {2'h2, rows[i].e});
      end
      // out-of-range rates clamp, odd rates round up
      wb(1'b1, 8'h00, 32'h10, rd);
      wb(1'b1, 8'h0c, 32'h4e20, rd);
      wb(1'b0, 8'h10, 32'h0, rd); chk("eff_mbps", rd, 32'h00c8_5140);
      wb(1'b1, 8'h00, 32'h00, rd);
      wb(1'b1, 8'h0c, 32'h1a, rd);
      wb(1'b0, 8'h10, 32'h0, rd); chk("eff_up", rd, 32'h32);
      wb(1'b1, 8'h0c, 32'h0a, rd);
      wb(1'b0, 8'h10, 32'h0, rd); chk("eff_min", rd, 32'h19);
      // two frames off, then two on: only the second enabled one overflows
      for (i = 0; i < 4; i++) begin
         if (i == 2) wb(1'b1, 8'h00, 32'h08, rd);
         src.send(mk(1'h0, 3'h0, 1'h0, 1'h0, 6'h00, 1'h0, 3'h0, 2'h0));
         #1;
         chk("drop", {res_valid_o, drop_o}, {1'b1, i == 3});
      end
      wb(1'b0, 8'h14, 32'h0, rd); chk("drops", rd, 32'h1);
      // mid-run reset: configuration, counter and tag map back to defaults
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b0, 8'h5c, 32'h0, rd); chk("tagmap_rst", rd, 32'hd);
      wb(1'b0, 8'h14, 32'h0, rd); chk("drops_rst2", rd, 32'h0);
      chk("cfg_rst", {class_identifier_o, early_discard_group_o, ingress_map_en_o, egress_map_en_o},
         32'h0);
      report_and_stop;
   end
endmodule // test_ingress_qos_classifier_policer
`default_nettype wire
